// ### pkg/snm_cfg.svh
`ifndef SNM_CFG_SVH
`define SNM_CFG_SVH

// Core clock period in nanoseconds (25 MHz).
`define SNM_CLK_NS 40

// Reset pulse driven by the master, least time.
`define SNM_RESET_LOW_TIME_NS 480000
`define SNM_RESET_LOW_CYC ((`SNM_RESET_LOW_TIME_NS + `SNM_CLK_NS - 1) / `SNM_CLK_NS)

// Whole listen window after release; it covers presence wait plus presence low.
`define SNM_RESET_REST_NS 480000
`define SNM_RESET_REST_CYC ((`SNM_RESET_REST_NS + `SNM_CLK_NS - 1) / `SNM_CLK_NS)

// Presence is sampled after the longest presence wait and before the shortest end.
`define SNM_PRES_SAMPLE_NS 70000
`define SNM_PRES_SAMPLE_CYC (`SNM_PRES_SAMPLE_NS / `SNM_CLK_NS)

// Longest low level the master may hold outside a reset pulse.
`define SNM_MAX_LOW_NS 120000

// One bit slot: active part plus recovery keeps the rate under 16.3 kbit/s.
`define SNM_SLOT_NS 70000
`define SNM_SLOT_CYC ((`SNM_SLOT_NS + `SNM_CLK_NS - 1) / `SNM_CLK_NS)

// Low time that starts a write-1 or read slot, least time.
`define SNM_LOW1_NS 6000
`define SNM_LOW1_CYC ((`SNM_LOW1_NS + `SNM_CLK_NS - 1) / `SNM_CLK_NS)

// Low time of a write-0 slot, least time.
`define SNM_LOW0_NS 60000
`define SNM_LOW0_CYC ((`SNM_LOW0_NS + `SNM_CLK_NS - 1) / `SNM_CLK_NS)

// Read sample point after the slot's falling edge, longest time.
`define SNM_READ_SAMPLE_NS 13000
`define SNM_READ_SAMPLE_CYC (`SNM_READ_SAMPLE_NS / `SNM_CLK_NS)

// Command codes the user sends with a byte write.
`define SNM_CMD_READ_ID 8'h33
`define SNM_CMD_READ_ID_LEGACY 8'h0F
`define SNM_CMD_ADDRESS 8'h55
`define SNM_CMD_BROADCAST 8'hCC
`define SNM_CMD_ENUMERATE 8'hF0

// Seed of the running check code and identity size in bits.
`define SNM_CRC_SEED 8'h00
`define SNM_ID_BITS 64

// Answer FIFO shape.
`define SNM_FIFO_DEPTH 4
`define SNM_FIFO_WIDTH 8

`endif

// ### pkg/snm_pkg.sv
package snm_pkg;

    // Operations the user may request on the line.
    typedef enum logic [1:0] {
        SNM_OP_RESET,
        SNM_OP_WRITE,
        SNM_OP_READ,
        SNM_OP_TRIPLET
    } snm_op_t;

    // Sequencer states of the line master.
    typedef enum logic [2:0] {
        SNM_ST_IDLE,
        SNM_ST_RST_LOW,
        SNM_ST_RST_LISTEN,
        SNM_ST_SLOT,
        SNM_ST_PUSH
    } snm_state_t;

endpackage

// ### tb/snm_dev_model.sv
`timescale 1ns/1ns
`include "snm_cfg.svh"
// Behavioural identity device on the shared line.
// It keys every slot off the master's falling edge and measures lows in real time.
module snm_dev_model #(
    parameter logic [7:0] FAMILY = 8'h5A, // Arbitrary value.
    parameter logic [47:0] SERIAL = 48'h1234_5678_9ABC,
    parameter int RESET_DET_NS = 480000,
    parameter bit LEGACY_OK = 1'b1
) (
    input wire logic line,
    input wire logic present,
    output logic pull_low
);
    logic [63:0] id; // Family in the low byte, check code in the top byte.
    logic [7:0] cmd; // Command bits as they arrive.
    int st; // 0 wait reset, 1 command, 2 send, 3 search, 4 silent.
    int cnt; // Bit index within the command or the identity.
    int ph; // Search step: 0 bit, 1 complement, 2 master's choice.
    time t0;

    // Check code over family and serial, shifted in low bit first.
    function automatic logic [7:0] crc8(input logic [55:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 56; i++)
        begin
            c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
        end
        return c;
    endfunction

    // One pass per slot; a long low overrides whatever phase was running.
    initial
    begin
        id = {crc8({SERIAL, FAMILY}), SERIAL, FAMILY};
        pull_low = 1'b0;
        st = 0;
        cnt = 0;
        ph = 0;
        cmd = 8'h00;
        forever
        begin
            @(negedge line);
            t0 = $time;
            // A zero is held well past the master's sample point.
            if ((st == 2 || (st == 3 && ph < 2)) && !(id[cnt] ^ ph[0]))
            begin
                pull_low = 1'b1;
                #30000;
                pull_low = 1'b0;
            end
            if (line !== 1'b1)
                @(posedge line);
            if ($time - t0 > RESET_DET_NS)
            begin
                #30000;
                pull_low = present;
                #65000;
                pull_low = 1'b0;
                st = 1;
                cnt = 0;
            end
            else if (st == 1)
            begin
                // Written bit is a one when the low ends within 15 us of the fall.
                cmd[cnt] = ($time - t0 < 15000);
                cnt++;
                if (cnt == 8)
                begin
                    cnt = 0;
                    ph = 0;
                    if (cmd == `SNM_CMD_READ_ID || (LEGACY_OK && cmd == `SNM_CMD_READ_ID_LEGACY))
                        st = 2;
                    else if (cmd == `SNM_CMD_ENUMERATE)
                        st = 3;
                    else
                        st = 4;
                end
            end
            else if (st == 2)
            begin
                cnt++;
                if (cnt == 64)
                    st = 4;
            end
            else if (st == 3)
            begin
                if (ph < 2)
                    ph++;
                else if (($time - t0 < 15000) != id[cnt])
                    st = 4;
                else
                begin
                    ph = 0;
                    cnt++;
                    if (cnt == 64)
                        st = 4;
                end
            end
        end
    end
endmodule

// ### tb/snm_master_checker.sv
`timescale 1ns/1ns
// Watches the line master's ports for pulse timing and handshake behaviour.
module snm_master_checker
    import snm_pkg::*;
#(
    parameter logic [15:0] RESET_LOW_CYC = 16'h2EE0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire snm_op_t cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [7:0] rsp_data,
    input wire logic busy,
    input wire logic crc_ok,
    input wire logic line_i,
    input wire logic line_o,
    input wire logic line_oe
);
    localparam int SLOT_CYC = 1750; // Whole slot, active part plus recovery.
    localparam int MAX_LOW_CYC = 3000; // 120 us at 25 MHz.
    logic [15:0] hi_cnt_q; // Cycles the master has held the line low so far.
    logic [15:0] gap_q; // Cycles since the master last began a pulse.
    logic oe_prev_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // Length of the current low; frozen with the design while clk_en is low.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            hi_cnt_q <= 16'h0000;
        else if (clk_en)
            hi_cnt_q <= line_oe ? hi_cnt_q + 16'h0001 : 16'h0000;
    end

    // Saturates, so the first pulse after reset never looks too early.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            gap_q <= 16'hFFFF;
            oe_prev_q <= 1'b0;
        end
        else if (clk_en)
        begin
            oe_prev_q <= line_oe;
            if (line_oe && !oe_prev_q)
                gap_q <= 16'h0001;
            else if (gap_q != 16'hFFFF)
                gap_q <= gap_q + 16'h0001;
        end
    end

    chk_line_o_low: assert property (line_o == 1'b0)
        else $error("line output level is not low");
    chk_idle_released: assert property (!busy |-> !line_oe)
        else $error("line pulled while idle");
    chk_low_bounded: assert property (line_oe |-> hi_cnt_q < MAX_LOW_CYC)
        else $error("line held low too long");
    chk_pulse_len: assert property ($fell(line_oe) |->
        hi_cnt_q == 16'h0096 || hi_cnt_q == 16'h05DC || hi_cnt_q == RESET_LOW_CYC)
        else $error("low pulse of unexpected length");
    chk_slot_rate: assert property ($rose(line_oe) |-> gap_q >= SLOT_CYC)
        else $error("pulses start too close together");
    chk_take_start: assert property (cmd_valid && cmd_ready |-> ##[1:2] line_oe)
        else $error("accepted request did not start a pulse");
    chk_ready_idle: assert property (cmd_ready == (clk_en && !busy))
        else $error("request ready while busy");
    chk_rsp_hold: assert property (rsp_valid && !rsp_ready |=>
        !clk_en || (rsp_valid && $stable(rsp_data)))
        else $error("answer changed before it was taken");

    cover property ($fell(line_oe) && hi_cnt_q == 16'h0096);
    cover property (cmd_valid && cmd_ready && cmd_op == SNM_OP_TRIPLET);
    cover property (rsp_valid && rsp_ready);
endmodule

// ### tb/tb_snm_master.sv
`timescale 1ns/1ns
`include "snm_cfg.svh"
module tb_snm_master
    import snm_pkg::*;
;
    localparam logic [7:0] FAMILY = 8'h5A; // Arbitrary value.
    localparam logic [47:0] SERIAL = 48'h1234_5678_9ABC;
    logic core_clk = 1'b0;
    logic rst_n;
    logic clk_en;
    logic cmd_valid;
    logic cmd_ready;
    snm_op_t cmd_op;
    logic [7:0] cmd_data;
    logic rsp_valid;
    logic rsp_ready;
    logic [7:0] rsp_data;
    logic busy;
    logic crc_ok;
    logic line_o;
    logic line_oe;
    logic present;
    logic pull_low;
    wire line; // Pulled up; low whenever either party pulls.
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;

    assign line = ~((line_oe & ~line_o) | pull_low);

    // Short reset low still outlasts a write-zero, so the device can tell them apart.
    snm_master #(.RESET_LOW_CYC(16'h07D0), .RESET_REST_CYC(16'h0BB8)) dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
        .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
        .rsp_data(rsp_data), .busy(busy), .crc_ok(crc_ok),
        .line_i(line), .line_o(line_o), .line_oe(line_oe)
    );

    snm_dev_model #(.FAMILY(FAMILY), .SERIAL(SERIAL), .RESET_DET_NS(70000)) dev_u (
        .line(line), .present(present), .pull_low(pull_low)
    );

    // 25 MHz core clock.
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Holds the request until taken, then waits for the operation to finish.
    task automatic do_op(input snm_op_t op, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_data = d;
        while (cmd_ready !== 1'b1 && n < 100)
        begin
            @(negedge core_clk);
            n++;
        end
        @(negedge core_clk);
        cmd_valid = 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 20000)
        begin
            @(negedge core_clk);
            n++;
        end
        check({7'h00, busy}, 8'h00);
    endtask

    task automatic get_rsp(output logic [7:0] d);
        int n;
        n = 0;
        @(negedge core_clk);
        while (rsp_valid !== 1'b1 && n < 100)
        begin
            @(negedge core_clk);
            n++;
        end
        check({7'h00, rsp_valid}, 8'h01);
        d = rsp_data;
        rsp_ready = 1'b1;
        @(negedge core_clk);
        rsp_ready = 1'b0;
    endtask

    // No device answers the reset; requests wait while the clock enable is low.
    task automatic t_absent;
        logic [7:0] r;
        present = 1'b0;
        do_op(SNM_OP_RESET, 8'h00);
        get_rsp(r);
        check(r, 8'h00);
        check({7'h00, crc_ok}, 8'h00);
        // Empty line reads ones twice, so the preferred zero is written and checked.
        do_op(SNM_OP_TRIPLET, 8'h00);
        get_rsp(r);
        check(r, 8'h03);
        check({7'h00, crc_ok}, 8'h01);
        clk_en = 1'b0;
        @(negedge core_clk);
        check({7'h00, cmd_ready}, 8'h00);
        clk_en = 1'b1;
    endtask

    // Reset, identity command, then the first bytes of the identity.
    task automatic t_read(input logic [7:0] code, input int nb);
        logic [7:0] r;
        logic [63:0] id;
        id = {8'h00, SERIAL, FAMILY};
        present = 1'b1;
        do_op(SNM_OP_RESET, 8'h00);
        get_rsp(r);
        check(r, 8'h01);
        check({7'h00, crc_ok}, 8'h00);
        do_op(SNM_OP_WRITE, code);
        for (int i = 0; i < nb; i++)
        begin
            do_op(SNM_OP_READ, 8'hFF);
            get_rsp(r);
            check(r, id[8*i +: 8]);
        end
    endtask

    // Search steps pile up unread until the answer buffer is full, then drain.
    task automatic t_search;
        logic [7:0] r;
        present = 1'b1;
        do_op(SNM_OP_RESET, 8'h00);
        do_op(SNM_OP_WRITE, `SNM_CMD_ENUMERATE);
        for (int i = 0; i < 3; i++)
            do_op(SNM_OP_TRIPLET, 8'h01);
        get_rsp(r);
        check(r, 8'h01);
        for (int i = 0; i < 3; i++)
        begin
            get_rsp(r);
            check(r, {5'h00, FAMILY[i], ~FAMILY[i], FAMILY[i]});
        end
        check({7'h00, rsp_valid}, 8'h00);
    endtask

    // Hang guard about a fifth above the expected run length of some 125000 cycles.
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 150000)
        begin
            err_count++;
            end_of_test;
        end
    end

    initial
    begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = SNM_OP_RESET;
        cmd_data = 8'h00;
        rsp_ready = 1'b0;
        present = 1'b1;
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        t_absent;
        t_read(`SNM_CMD_READ_ID_LEGACY, 1);
        t_read(`SNM_CMD_READ_ID, 2);
        t_search;
        end_of_test;
    end
endmodule

bind snm_master snm_master_checker #(.RESET_LOW_CYC(RESET_LOW_CYC)) chk_u (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_data(rsp_data), .busy(busy), .crc_ok(crc_ok),
    .line_i(line_i), .line_o(line_o), .line_oe(line_oe)
);

// ### verilog/snm_fifo.sv
`timescale 1ns/1ns
module snm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Storage array, read and written by pointer.
    logic [WIDTH-1:0] mem_q [DEPTH];
    // Write and read pointers.
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    // Fill level; one bit wider so that full and empty differ.
    logic [PW:0] cnt_q;
    logic push;
    logic pop;

    // Handshakes count only on enabled cycles, so the ready flags follow clk_en.
    assign in_ready = clk_en && (cnt_q != (PW + 1)'(DEPTH));
    assign out_valid = clk_en && (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];

    // Data words are kept without reset; only the pointers and the fill level need a defined start.
    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointer and level bookkeeping, wrapping at DEPTH.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_q <= cnt_q + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

endmodule

// ### verilog/snm_master.sv
`timescale 1ns/1ns
`include "snm_cfg.svh"
module snm_master
    import snm_pkg::*;
#(
    parameter logic [15:0] RESET_LOW_CYC = 16'(`SNM_RESET_LOW_CYC),
    parameter logic [15:0] RESET_REST_CYC = 16'(`SNM_RESET_REST_CYC)
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire snm_op_t cmd_op,
    input wire logic [7:0] cmd_data,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic [7:0] rsp_data,
    output logic busy,
    output logic crc_ok,
    input wire logic line_i,
    output logic line_o,
    output logic line_oe
);

    // Timing counts sized to the slot counter.
    localparam logic [15:0] SLOT_CYC = 16'(`SNM_SLOT_CYC);
    localparam logic [15:0] LOW1_CYC = 16'(`SNM_LOW1_CYC);
    localparam logic [15:0] LOW0_CYC = 16'(`SNM_LOW0_CYC);
    localparam logic [15:0] READ_SAMPLE_CYC = 16'(`SNM_READ_SAMPLE_CYC);
    localparam logic [15:0] PRES_SAMPLE_CYC = 16'(`SNM_PRES_SAMPLE_CYC);

    // Two-stage synchroniser for the shared line.
    logic line_s1_q;
    logic line_s2_q;
    // Sequencer state and its cycle counter.
    snm_state_t state_q;
    logic [15:0] cnt_q;
    // Operation in progress.
    snm_op_t op_q;
    // Byte shifter and bit index within the byte.
    logic [7:0] shift_q;
    logic [2:0] bit_q;
    // Step inside an enumeration triplet, and the bits seen in it.
    logic [1:0] step_q;
    logic id_q;
    logic pref_q;
    // Low time of the current slot.
    logic [15:0] low_q;
    // Line level caught at the sample point of the current slot.
    logic smp_q;
    // Presence seen during the last reset listen window.
    logic pres_q;
    // Word waiting to enter the answer FIFO.
    logic [7:0] rsp_q;
    // Registered pin drive.
    logic drive_q;
    // Running check code over received identity bits.
    logic [7:0] crc_q;
    logic crc_ok_q;
    // Check code update request for this cycle.
    logic crc_en;
    logic crc_bit;
    // Slot completion and the derived enumeration direction.
    logic slot_end;
    logic dir;
    logic fifo_ready;
    logic accept;

    // One step of the reflected x8+x5+x4+1 code.
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
        logic fb;
        fb = c[0] ^ b;
        crc_step = {1'b0, c[7:1]} ^ (fb ? 8'h8C : 8'h00);
    endfunction

    // The line is never driven high; only the enable changes.
    assign line_o = 1'b0;
    assign line_oe = drive_q;
    assign busy = (state_q != SNM_ST_IDLE);
    assign crc_ok = crc_ok_q;
    assign cmd_ready = clk_en && (state_q == SNM_ST_IDLE);
    assign accept = cmd_valid && cmd_ready;
    assign slot_end = (state_q == SNM_ST_SLOT) && (cnt_q == SLOT_CYC - 16'h0001);

    // Enumeration direction: a clear disagreement follows the identity bit,
    // otherwise the user's preferred branch is taken.
    assign dir = (id_q != smp_q) ? id_q : pref_q;

    // The line crosses in from outside, so it is read only after two flops.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            line_s1_q <= 1'b1;
            line_s2_q <= 1'b1;
        end
        else if (clk_en)
        begin
            line_s1_q <= line_i;
            line_s2_q <= line_s1_q;
        end
    end

    // Pin drive is registered so the open-drain enable cannot glitch.
    // Being one cycle late on both edges keeps every low time unchanged.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            drive_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (state_q == SNM_ST_RST_LOW)
            begin
                drive_q <= 1'b1;
            end
            else if (state_q == SNM_ST_SLOT)
            begin
                drive_q <= (cnt_q < low_q);
            end
            else
            begin
                drive_q <= 1'b0;
            end
        end
    end

    // Sample points: read bits early in the slot, presence early in the window.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            smp_q <= 1'b1;
            pres_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (state_q == SNM_ST_SLOT && cnt_q == READ_SAMPLE_CYC)
            begin
                smp_q <= line_s2_q;
            end
            if (state_q == SNM_ST_RST_LOW)
            begin
                pres_q <= 1'b0;
            end
            else if (state_q == SNM_ST_RST_LISTEN && cnt_q == PRES_SAMPLE_CYC)
            begin
                pres_q <= ~line_s2_q;
            end
        end
    end

    // Which bit, if any, enters the check code at the end of this slot.
    always_comb
    begin
        crc_en = 1'b0;
        crc_bit = smp_q;
        if (slot_end && op_q == SNM_OP_READ)
        begin
            crc_en = 1'b1;
        end
        else if (slot_end && op_q == SNM_OP_TRIPLET && step_q == 2'd2)
        begin
            crc_en = 1'b1;
            crc_bit = pref_q;
        end
    end

    // Check code: cleared by a reset pulse, zero after a clean 64-bit identity.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            crc_q <= `SNM_CRC_SEED;
            crc_ok_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (accept && cmd_op == SNM_OP_RESET)
            begin
                crc_q <= `SNM_CRC_SEED;
                crc_ok_q <= 1'b0;
            end
            else if (crc_en)
            begin
                crc_q <= crc_step(crc_q, crc_bit);
                crc_ok_q <= (crc_step(crc_q, crc_bit) == 8'h00);
            end
        end
    end

    // Main sequencer. A pause with clk_en low freezes the line as it is, but a full answer FIFO
    // stalls only in SNM_ST_PUSH, between slots with the line released, never inside one.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_q <= SNM_ST_IDLE;
            cnt_q <= 16'h0000;
            op_q <= SNM_OP_RESET;
            shift_q <= 8'h00;
            bit_q <= 3'd0;
            step_q <= 2'd0;
            id_q <= 1'b0;
            pref_q <= 1'b0;
            low_q <= 16'h0000;
            rsp_q <= 8'h00;
        end
        else if (clk_en)
        begin
            unique case (state_q)
                // Take a new request; byte and bit operations start a slot at once.
                SNM_ST_IDLE:
                begin
                    if (accept)
                    begin
                        op_q <= cmd_op;
                        cnt_q <= 16'h0000;
                        shift_q <= cmd_data;
                        bit_q <= 3'd0;
                        step_q <= 2'd0;
                        pref_q <= cmd_data[0];
                        low_q <= LOW1_CYC;
                        if (cmd_op == SNM_OP_RESET)
                        begin
                            state_q <= SNM_ST_RST_LOW;
                        end
                        else
                        begin
                            state_q <= SNM_ST_SLOT;
                            if (cmd_op == SNM_OP_WRITE && !cmd_data[0])
                            begin
                                low_q <= LOW0_CYC;
                            end
                        end
                    end
                end
                // Hold the line low for the whole reset pulse.
                SNM_ST_RST_LOW:
                begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_q == RESET_LOW_CYC - 16'h0001)
                    begin
                        cnt_q <= 16'h0000;
                        state_q <= SNM_ST_RST_LISTEN;
                    end
                end
                // Listen through the presence window, then report presence.
                SNM_ST_RST_LISTEN:
                begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_q == RESET_REST_CYC - 16'h0001)
                    begin
                        rsp_q <= {7'h00, pres_q};
                        state_q <= SNM_ST_PUSH;
                    end
                end
                // One bit slot; its close decides the next slot or the answer.
                SNM_ST_SLOT:
                begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (slot_end)
                    begin
                        cnt_q <= 16'h0000;
                        low_q <= LOW1_CYC;
                        unique case (op_q)
                            // Command or data byte out, lowest bit first.
                            SNM_OP_WRITE:
                            begin
                                shift_q <= {1'b0, shift_q[7:1]};
                                bit_q <= bit_q + 3'd1;
                                if (bit_q == 3'd7)
                                begin
                                    state_q <= SNM_ST_IDLE;
                                end
                                else if (!shift_q[1])
                                begin
                                    low_q <= LOW0_CYC;
                                end
                            end
                            // Byte in, lowest bit first.
                            SNM_OP_READ:
                            begin
                                shift_q <= {smp_q, shift_q[7:1]};
                                bit_q <= bit_q + 3'd1;
                                if (bit_q == 3'd7)
                                begin
                                    rsp_q <= {smp_q, shift_q[7:1]};
                                    state_q <= SNM_ST_PUSH;
                                end
                            end
                            // Bit, complement, then the chosen direction written back.
                            SNM_OP_TRIPLET:
                            begin
                                step_q <= step_q + 2'd1;
                                if (step_q == 2'd0)
                                begin
                                    id_q <= smp_q;
                                end
                                else if (step_q == 2'd1)
                                begin
                                    pref_q <= dir;
                                    rsp_q <= {5'h00, dir, smp_q, id_q};
                                    if (!dir)
                                    begin
                                        low_q <= LOW0_CYC;
                                    end
                                end
                                else
                                begin
                                    state_q <= SNM_ST_PUSH;
                                end
                            end
                            default:
                            begin
                                state_q <= SNM_ST_IDLE;
                            end
                        endcase
                    end
                end
                // Wait with the line idle until the FIFO takes the answer.
                SNM_ST_PUSH:
                begin
                    if (fifo_ready)
                    begin
                        state_q <= SNM_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Answers travel through a short FIFO so the user may drain them late.
    snm_fifo #(
        .WIDTH(`SNM_FIFO_WIDTH),
        .DEPTH(`SNM_FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .in_valid(state_q == SNM_ST_PUSH),
        .in_ready(fifo_ready),
        .in_data(rsp_q),
        .out_valid(rsp_valid),
        .out_ready(rsp_ready),
        .out_data(rsp_data)
    );

endmodule
